// File: rtl/sbm_bus_master.v
`timescale 1ns/1ps
`include "sbm_map.vh"
// Bus cycle master for a 16-bit parallel bus with handshake termination.
// Each system clock cycle is one half-state of the bus clock; the bus
// clock is high in even states and low in odd states.
module sbm_bus_master #(
	parameter AW = 23,
	parameter DW = 16
) (
	// Clock and reset
	input wire sys_clk,
	input wire nrst,
	// Core request side
	input wire req,
	input wire req_write,
	input wire [2:0] req_fc,
	input wire [AW-1:0] req_addr,
	input wire [DW-1:0] req_wdata,
	input wire req_upper,
	input wire req_lower,
	// Core answer side
	output reg busy_reg,
	output reg done_reg,
	output reg fault_trap_reg,
	output reg [DW-1:0] rd_data_reg,
	// Bus clock
	output wire bus_clk,
	// Bus control outputs
	output reg [2:0] fc_reg,
	output reg read_write_reg,
	output reg address_strobe_n,
	output reg upper_byte_strobe_n,
	output reg lower_byte_strobe_n,
	// Address bus
	output reg [AW-1:0] addr_out_reg,
	output reg addr_oe_reg,
	// Data bus
	input wire [DW-1:0] data_in,
	output reg [DW-1:0] data_out_reg,
	output reg data_oe_reg,
	// Termination inputs from the slave
	input wire transfer_ack_n,
	input wire bus_fault_n,
	input wire halt_n
);

	// Bus states; waits are a low and a high half inserted after S4
	localparam ST_IDLE = 4'h0;
	localparam ST_S0 = 4'h1;
	localparam ST_S1 = 4'h2;
	localparam ST_S2 = 4'h3;
	localparam ST_S3 = 4'h4;
	localparam ST_S4 = 4'h5;
	localparam ST_S5 = 4'h6;
	localparam ST_S6 = 4'h7;
	localparam ST_S7 = 4'h8;
	localparam ST_WLO = 4'h9;
	localparam ST_WHI = 4'ha;
	localparam ST_HOLD = 4'hb;

	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg write_reg;
	reg [2:0] fc_hold_reg;
	reg [AW-1:0] addr_hold_reg;
	reg [DW-1:0] wdata_hold_reg;
	reg upper_reg;
	reg lower_reg;
	reg fault_seen_reg;
	reg halt_seen_reg;
	wire [`SBM_SYNC_WIDTH-1:0] sync_word;
	wire ack_s;
	wire fault_s;
	wire halt_s;
	wire [DW-1:0] data_s;
	wire term_s;
	wire start_ok;
	wire rerun_ok;

	// Ack, fault, halt and data bus all come from outside this clock
	sbm_sync #(
		.WIDTH(`SBM_SYNC_WIDTH)
	) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.async_in({halt_n, bus_fault_n, transfer_ack_n, data_in}),
		.sync_out(sync_word)
	);

	sbm_half_clk u_half_clk (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.bus_clk(bus_clk)
	);

	// Synchronised levels, active high
	assign ack_s = ~sync_word[`SBM_SYNC_ACK];
	assign fault_s = ~sync_word[`SBM_SYNC_FAULT];
	assign halt_s = ~sync_word[`SBM_SYNC_HALT];
	assign data_s = sync_word[DW-1:0];
	assign term_s = ack_s | fault_s;

	// A cycle may start only where the bus clock is about to rise
	assign start_ok = ~bus_clk;
	assign rerun_ok = ~bus_clk & ~halt_s;

	// Next state; each state is one half of a bus clock period
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (req && !done_reg && !fault_trap_reg && start_ok) begin
					state_next = ST_S0;
				end
			end
			ST_S0: begin
				state_next = ST_S1;
			end
			ST_S1: begin
				state_next = ST_S2;
			end
			ST_S2: begin
				state_next = ST_S3;
			end
			ST_S3: begin
				state_next = ST_S4;
			end
			// Responses only count at the edges that end S4 and each high wait half
			ST_S4, ST_WHI: begin
				if (term_s) begin
					state_next = ST_S5;
				end else begin
					state_next = ST_WLO;
				end
			end
			ST_WLO: begin
				state_next = ST_WHI; // Whole clock per wait
			end
			ST_S5: begin
				state_next = ST_S6;
			end
			ST_S6: begin
				state_next = ST_S7;
			end
			ST_S7: begin
				if (fault_seen_reg && halt_seen_reg) begin
					state_next = ST_HOLD;
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_HOLD: begin
				if (rerun_ok) begin
					state_next = ST_S0; // Same access again
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// State register and all bus outputs except the bus clock, changed on entry to a state
	always @(posedge sys_clk) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			fault_trap_reg <= 1'b0;
			rd_data_reg <= {DW{1'b0}};
			fc_reg <= `SBM_FC_RESET;
			read_write_reg <= `SBM_RW_IDLE;
			address_strobe_n <= `SBM_STROBE_IDLE;
			upper_byte_strobe_n <= `SBM_STROBE_IDLE;
			lower_byte_strobe_n <= `SBM_STROBE_IDLE;
			addr_out_reg <= {AW{1'b0}};
			addr_oe_reg <= 1'b0;
			data_out_reg <= {DW{1'b0}};
			data_oe_reg <= 1'b0;
			write_reg <= 1'b0;
			fc_hold_reg <= `SBM_FC_RESET;
			addr_hold_reg <= {AW{1'b0}};
			wdata_hold_reg <= {DW{1'b0}};
			upper_reg <= 1'b0;
			lower_reg <= 1'b0;
			fault_seen_reg <= 1'b0;
			halt_seen_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			done_reg <= 1'b0;
			fault_trap_reg <= 1'b0;
			case (state_reg)
				// Take the request; it is held here for a possible rerun
				ST_IDLE: begin
					if (state_next == ST_S0) begin
						busy_reg <= 1'b1;
						write_reg <= req_write;
						fc_hold_reg <= req_fc;
						addr_hold_reg <= req_addr;
						wdata_hold_reg <= req_wdata;
						upper_reg <= req_upper;
						lower_reg <= req_lower;
						fc_reg <= req_fc;
						read_write_reg <= 1'b1;
					end
				end
				ST_HOLD: begin
					if (state_next == ST_S0) begin
						fc_reg <= fc_hold_reg;
						read_write_reg <= 1'b1;
					end
				end
				// Address goes out in the low half of S1
				ST_S0: begin
					addr_out_reg <= addr_hold_reg;
					addr_oe_reg <= 1'b1;
				end
				// Address strobe always; data strobes now only for reads
				ST_S1: begin
					address_strobe_n <= 1'b0;
					if (write_reg) begin
						read_write_reg <= 1'b0;
					end else begin
						upper_byte_strobe_n <= ~upper_reg;
						lower_byte_strobe_n <= ~lower_reg;
					end
				end
				// Write data leaves high impedance entering S3
				ST_S2: begin
					if (write_reg) begin
						data_out_reg <= wdata_hold_reg;
						data_oe_reg <= 1'b1;
					end
				end
				// Write strobes follow the data by one half clock
				ST_S3: begin
					if (write_reg) begin
						upper_byte_strobe_n <= ~upper_reg;
						lower_byte_strobe_n <= ~lower_reg;
					end
				end
				// Record how the cycle was terminated; no output moves
				ST_S4, ST_WHI: begin
					if (term_s) begin
						fault_seen_reg <= fault_s;
						halt_seen_reg <= halt_s;
					end
				end
				// S5 and S6 leave the bus alone
				ST_S5: begin
					fc_reg <= fc_reg;
				end
				// Strobes negate and read data is taken entering S7
				ST_S6: begin
					address_strobe_n <= `SBM_STROBE_IDLE;
					upper_byte_strobe_n <= `SBM_STROBE_IDLE;
					lower_byte_strobe_n <= `SBM_STROBE_IDLE;
					if (!write_reg) begin
						rd_data_reg <= data_s;
					end
				end
				// Release the buses and report the outcome
				ST_S7: begin
					addr_oe_reg <= 1'b0;
					data_oe_reg <= 1'b0;
					read_write_reg <= `SBM_RW_IDLE;
					if (fault_seen_reg && halt_seen_reg) begin
						busy_reg <= 1'b1;
					end else if (fault_seen_reg) begin
						busy_reg <= 1'b0;
						fault_trap_reg <= 1'b1;
					end else begin
						busy_reg <= 1'b0;
						done_reg <= 1'b1;
					end
				end
				default: begin
					busy_reg <= busy_reg;
				end
			endcase
		end
	end

endmodule

// File: shared/sbm_map.vh
// Notes on behaviour
// - Cycle is eight half-states plus whole-clock waits
// - S0 rising edge drives function code, read high
// - Entering S1 drives the target address
// - S2 asserts address strobe; reads assert data strobes
// - Write cycles drive read/write low in S2
// - Write drives data entering S3; reads idle
// - Write asserts data strobes at S4; reads idle
// - Responses ignored until the S4-to-S5 edge
// - Ack or fault at S4 end advances to S5
// - No termination keeps inserting whole-clock wait states
// - Outputs hold in S5, and S6 of writes
// - Entering S7 negates strobes; reads capture data
// - Ending S7 releases address; writes release data, read
// - Ack and fault inputs synchronised to the clock
// - Read data captured one falling edge after ack
// - Timely ack gives a four-clock cycle, no waits
// - Fault without halt ends cycle, requests trap
// - Fault with halt ends cycle, reruns after halt
`ifndef SBM_MAP_VH
`define SBM_MAP_VH

// Reset and idle levels of the bus outputs
`define SBM_STROBE_IDLE 1'b1
`define SBM_RW_IDLE 1'b1
`define SBM_FC_RESET 3'h0
`define SBM_BUS_CLK_RESET 1'b0

// Positions of the synchronised inputs in the shared synchroniser word
`define SBM_SYNC_ACK 16
`define SBM_SYNC_FAULT 17
`define SBM_SYNC_HALT 18
`define SBM_SYNC_WIDTH 19

// Number of flip-flops in each synchroniser
`define SBM_SYNC_STAGES 2

`endif

// File: rtl/sbm_sync.v
`timescale 1ns/1ps
// Multi-bit two-flop synchroniser; bits are independent, not a coherent word
module sbm_sync #(
	parameter WIDTH = 19
) (
	// Clock and reset
	input wire sys_clk,
	input wire nrst,
	// Asynchronous input and its synchronised copy
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_reg;

	// First stage is read by the second stage only
	always @(posedge sys_clk) begin
		if (!nrst) begin
			meta_reg <= {WIDTH{1'b1}};
			sync_out <= {WIDTH{1'b1}};
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

// File: rtl/sbm_half_clk.v
`timescale 1ns/1ps
`include "sbm_map.vh"
// Bus clock divider: toggles every system clock, one half-state per cycle
module sbm_half_clk (
	// Clock and reset
	input wire sys_clk,
	input wire nrst,
	// Bus clock driven to the slave
	output reg bus_clk
);

	// Free running so a synchronous slave always sees edges
	always @(posedge sys_clk) begin
		if (!nrst) begin
			bus_clk <= `SBM_BUS_CLK_RESET;
		end else begin
			bus_clk <= ~bus_clk;
		end
	end

endmodule

// File: sim/sbm_bus_sva.sv
`timescale 1ns/1ps
// Pin timing watch, counted in system clock cycles
module sbm_bus_sva (
	input wire sys_clk,
	input wire nrst,
	input wire read_write_reg,
	input wire address_strobe_n,
	input wire upper_byte_strobe_n,
	input wire lower_byte_strobe_n,
	input wire addr_oe_reg,
	input wire data_oe_reg,
	input wire transfer_ack_n,
	input wire bus_fault_n
);
	// Short names for the strobes and for any termination
	wire as_n = address_strobe_n;
	wire ds_n = upper_byte_strobe_n & lower_byte_strobe_n;
	wire term = !(transfer_ack_n && bus_fault_n);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	AST_RST: assert property (disable iff (1'b0) !nrst |=> as_n && ds_n
		&& read_write_reg && !addr_oe_reg && !data_oe_reg) else $error("bad idle");
	AST_ADDR: assert property ($rose(addr_oe_reg) |=> $fell(as_n))
		else $error("strobe late");
	AST_RD: assert property ($fell(as_n) && read_write_reg |-> !ds_n)
		else $error("read strobes late");
	AST_WR: assert property ($fell(as_n) && !read_write_reg
		|-> ds_n ##1 data_oe_reg && ds_n ##1 !ds_n) else $error("write order");
	AST_MIN: assert property ($fell(as_n) |-> (!as_n)[*5])
		else $error("cycle short");
	AST_FAST: assert property ($fell(as_n) && term |-> ##5 $rose(as_n))
		else $error("cycle long");
	AST_WAIT: assert property ($fell(as_n) ##0 (!term)[*4] |=> (!as_n)[*2])
		else $error("wait lost");
	AST_END: assert property ($rose(as_n) |-> ds_n ##1 !addr_oe_reg
		&& read_write_reg && !data_oe_reg) else $error("bus kept");
endmodule

bind sbm_bus_master sbm_bus_sva chk (
	.sys_clk(sys_clk),
	.nrst(nrst),
	.read_write_reg(read_write_reg),
	.address_strobe_n(address_strobe_n),
	.upper_byte_strobe_n(upper_byte_strobe_n),
	.lower_byte_strobe_n(lower_byte_strobe_n),
	.addr_oe_reg(addr_oe_reg),
	.data_oe_reg(data_oe_reg),
	.transfer_ack_n(transfer_ack_n),
	.bus_fault_n(bus_fault_n)
);

// File: sim/sbm_slave_model.sv
`timescale 1ns/1ps
// Clocked slave; answers after two half-states per wait
module sbm_slave_model (
	input wire sys_clk,
	input wire address_strobe_n,
	input wire [15:0] rd_word,
	input wire [3:0] waits,
	input wire fault_mode,
	output wire transfer_ack_n,
	output wire bus_fault_n,
	output wire [15:0] data_in
);
	reg [4:0] cnt_reg = 5'h00;
	wire hit = !address_strobe_n && cnt_reg >= {waits, 1'b0};
	// Cycles since the strobe fell
	always @(posedge sys_clk) begin
		cnt_reg <= address_strobe_n ? 5'h00 : cnt_reg + 5'h01;
	end
	// Dropped with the strobe, so no answer leaks into the next cycle
	assign transfer_ack_n = !(hit && !fault_mode);
	assign bus_fault_n = !(hit && fault_mode);
	// Word held while selected, inverse otherwise
	assign data_in = address_strobe_n ? ~rd_word : rd_word;
endmodule

// File: sim/tb_sbm_bus_master.sv
`timescale 1ns/1ps
// Core-side scenarios against a clocked slave
module tb_sbm_bus_master;
	reg sys_clk = 1'b0, nrst = 1'b0, req = 1'b0, req_write = 1'b0, halt_n = 1'b1;
	reg req_upper = 1'b0, req_lower = 1'b0, fault_mode = 1'b0;
	reg [2:0] req_fc = 3'h0;
	reg [3:0] waits = 4'h0;
	reg [15:0] req_wdata = 16'h0000;
	reg [22:0] req_addr = 23'h000000;
	wire busy_reg, done_reg, fault_trap_reg, bus_clk, read_write_reg, addr_oe_reg;
	wire data_oe_reg, address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n;
	wire transfer_ack_n, bus_fault_n;
	wire [2:0] fc_reg;
	wire [15:0] rd_data_reg, data_out_reg, data_in;
	wire [22:0] addr_out_reg;
	wire [1:0] ds = {upper_byte_strobe_n, lower_byte_strobe_n};
	integer num_errors = 0, total_checks = 0, n, k;
	sbm_bus_master DUT (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.req(req),
		.req_write(req_write),
		.req_fc(req_fc),
		.req_addr(req_addr),
		.req_wdata(req_wdata),
		.req_upper(req_upper),
		.req_lower(req_lower),
		.busy_reg(busy_reg),
		.done_reg(done_reg),
		.fault_trap_reg(fault_trap_reg),
		.rd_data_reg(rd_data_reg),
		.bus_clk(bus_clk),
		.fc_reg(fc_reg),
		.read_write_reg(read_write_reg),
		.address_strobe_n(address_strobe_n),
		.upper_byte_strobe_n(upper_byte_strobe_n),
		.lower_byte_strobe_n(lower_byte_strobe_n),
		.addr_out_reg(addr_out_reg),
		.addr_oe_reg(addr_oe_reg),
		.data_in(data_in),
		.data_out_reg(data_out_reg),
		.data_oe_reg(data_oe_reg),
		.transfer_ack_n(transfer_ack_n),
		.bus_fault_n(bus_fault_n),
		.halt_n(halt_n)
	);
	// Reads return the word last handed to the request port
	sbm_slave_model slave (
		.sys_clk(sys_clk),
		.address_strobe_n(address_strobe_n),
		.rd_word(req_wdata),
		.waits(waits),
		.fault_mode(fault_mode),
		.transfer_ack_n(transfer_ack_n),
		.bus_fault_n(bus_fault_n),
		.data_in(data_in)
	);
	// Free-running system clock
	initial forever #50 sys_clk = ~sys_clk;
	task check(input logic [31:0] seen, exp, input string what);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task close_out;
		begin
			$display("checks %0d mismatches %0d", total_checks, num_errors);
			if (num_errors == 0 && total_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// One access, timed from strobe assertion to the answer pulse
	task xfer(input logic w, input logic [22:0] a, input logic [15:0] d,
		input logic [1:0] bs, input logic [3:0] ws, input logic f);
		begin
			@(posedge sys_clk);
			req <= 1'b1;
			req_write <= w;
			req_fc <= {w, a[1:0]};
			req_addr <= a;
			req_wdata <= d;
			{req_upper, req_lower} <= bs;
			waits <= ws;
			fault_mode <= f;
			for (n = 0; n < 50 && address_strobe_n !== 1'b0; n = n + 1)
				@(negedge sys_clk);
			check({fc_reg, addr_out_reg}, {w, a[1:0], a}, "fc addr");
			// S2 is a high half of the bus clock, with the address driven
			check({busy_reg, bus_clk, addr_oe_reg, read_write_reg}, {3'h7, !w}, "s2 pins");
			for (n = 0; n < 60 && done_reg !== 1'b1 && fault_trap_reg !== 1'b1; n = n + 1) begin
				if (n == 2)
					check({data_oe_reg, w ? data_out_reg : d, ds}, {w, d, ~bs}, "s4");
				@(negedge sys_clk);
			end
			check(n, 6 + 2 * ws, "cycles");
			check({done_reg, fault_trap_reg, busy_reg}, {!f, f, 1'b0}, "answer");
			if (!w && !f)
				check(rd_data_reg, d, "rdata");
			@(posedge sys_clk);
			req <= 1'b0;
		end
	endtask
	// Zero-wait reads and writes over each byte select
	task t_fast;
		begin
			for (k = 1; k < 8; k = k + 1)
				if (k[1:0] != 2'h0)
					xfer(k[2], 23'h555550 + k[2:0], 16'h3c00 + k[2:0], k[1:0], 4'h0, 1'b0);
			$display("fast done");
		end
	endtask
	// Waits on both kinds, then a fault asking for a trap
	task t_slow;
		begin
			xfer(1'b0, 23'h7fffff, 16'hffff, 2'h3, 4'h1, 1'b0);
			xfer(1'b1, 23'h000000, 16'h0000, 2'h1, 4'h3, 1'b0);
			xfer(1'b0, 23'h2aaaaa, 16'h8001, 2'h2, 4'h1, 1'b1);
			$display("slow done");
		end
	endtask
	// Fault with halt holds the same access until halt goes away
	task t_rerun;
		reg seen;
		begin
			@(posedge sys_clk);
			halt_n <= 1'b0;
			fault_mode <= 1'b1;
			waits <= 4'h0;
			req <= 1'b1;
			seen = 1'b0;
			repeat (30) begin
				@(negedge sys_clk);
				seen = seen | done_reg | fault_trap_reg;
			end
			check({seen, busy_reg, addr_oe_reg}, 3'h2, "held");
			@(posedge sys_clk);
			halt_n <= 1'b1;
			xfer(1'b0, 23'h2aaaaa, 16'h8001, 2'h2, 4'h0, 1'b0);
			$display("rerun done");
		end
	endtask
	// Reset, the scenarios in turn, then the verdict
	initial begin
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		check({address_strobe_n, ds, read_write_reg, addr_oe_reg, data_oe_reg}, 6'h3c, "idle");
		@(posedge sys_clk);
		nrst <= 1'b1;
		t_fast;
		t_slow;
		t_rerun;
		close_out;
	end
	// Watchdog, far beyond the under two hundred cycles the tests take
	initial begin
		#300000;
		num_errors = num_errors + 1;
		close_out;
	end
endmodule
